/* File: verilog/rx_gain_pkg.sv */
`default_nettype none
package rx_gain_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_BAND = 6'h01;
  localparam logic [5:0] IDX_GAIN = 6'h0b;
  localparam logic [5:0] IDX_CAL  = 6'h0f;
  localparam logic [5:0] IDX_CFG  = 6'h10;
  localparam logic [5:0] IDX_STEP = 6'h11;
  localparam logic [5:0] IDX_DCO  = 6'h12;
  localparam logic [5:0] IDX_STAT = 6'h13;

  localparam int CAL_VCM_BIT  = 8;
  localparam int CFG_SWAPI    = 4;
  localparam int CFG_SWAPQ    = 5;
  localparam int CFG_DHPF     = 8;
  localparam int CFG_DEN      = 9;
  localparam int STEP_LNA_LSB = 4;
  localparam int DCO_SLOW_LSB = 4;
  localparam int DCO_SET_LSB  = 8;
  localparam int STAT_REL_LSB = 16;
  localparam int STAT_BUSY    = 24;

  localparam logic [2:0] FM_WCDMA7 = 3'h0;
  localparam logic [2:0] FM_WCDMA5 = 3'h1;
  localparam logic [2:0] FM_GSM    = 3'h2;

  localparam logic [6:0] RST_GAIN    = 7'h00;
  localparam logic [4:0] RST_CAL     = 5'h08;
  localparam logic [3:0] RST_MIXSTEP = 4'h4;
  localparam logic [3:0] RST_LNASTEP = 4'h8;
  localparam logic [3:0] RST_FAST    = 4'h2;
  localparam logic [3:0] RST_SLOW    = 4'h6;
  localparam logic [7:0] RST_SETTLE  = 8'h40;

  localparam int X_WCDMA        = 8;
  localparam int X_GSM          = 17;
  localparam int MIX_BASE_WCDMA = 18;
  localparam int MIX_BASE_GSM   = 27;
  localparam int VGA_BASE       = -6;
  localparam int STEP_RF        = 6;
  localparam int STEP_FILT      = 12;
  localparam int LNA_MAX        = 3;
  localparam int MIX_MAX        = 2;
  localparam int FILT_MAX       = 3;
  localparam int VGA_MAX        = 24;
  localparam int THR_UNIT       = 4;
  localparam int REL_MAX = STEP_RF * (LNA_MAX + MIX_MAX)
                         + STEP_FILT * FILT_MAX + VGA_MAX;

  typedef struct packed {
    logic [1:0] lna;
    logic [1:0] mix;
    logic [1:0] filt;
    logic [4:0] vga;
  } gain_set_t;

  typedef struct packed {
    logic [3:0] fast_shift;
    logic [3:0] slow_shift;
    logic [7:0] settle;
    logic       hpf;
    logic       en;
  } dco_cfg_t;
endpackage
`default_nettype wire

/* File: verilog/dco_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module dco_channel (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 trig,
  input  wire rx_gain_pkg::dco_cfg_t cfg,
  input  wire logic signed [7:0]    adc,
  output logic signed [7:0]         trim,
  output logic                      busy
);
  typedef enum logic [1:0] {DC_HOLD, DC_FAST, DC_TRACK} dc_state_t;

  dc_state_t          state;
  dc_state_t          next_state;
  logic [7:0]         count;
  logic [7:0]         next_count;
  logic signed [15:0] acc;
  logic signed [15:0] next_acc;
  logic signed [16:0] step;
  logic signed [16:0] sum;
  logic               next_busy;

  assign trim = acc[15:8];

  always_comb begin
    next_state = state;
    next_count = count;
    next_acc   = acc;
    step = 17'(signed'({adc, 8'h00})) >>> ((state == DC_FAST) ?
           cfg.fast_shift : cfg.slow_shift);
    sum  = {acc[15], acc} - step;
    case (state)
      DC_HOLD: ;
      DC_FAST: begin
        if (count == 8'h00) begin
          next_state = cfg.hpf ? DC_TRACK : DC_HOLD;
        end else begin
          next_count = count - 8'h01;
        end
      end
      DC_TRACK: ;
      default: next_state = DC_HOLD;
    endcase
    // Error fed back through the trim code, saturated
    if (state != DC_HOLD) begin
      if (sum > 17'sh07fff) begin
        next_acc = 16'sh7fff;
      end else if (sum < -17'sh08000) begin
        next_acc = -16'sh8000;
      end else begin
        next_acc = sum[15:0];
      end
    end
    if (!cfg.en) begin
      next_state = DC_HOLD;
    end else if (trig) begin
      next_state = DC_FAST;
      next_count = cfg.settle;
    end
    next_busy = (next_state == DC_FAST);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= DC_HOLD;
      count <= 8'h00;
      acc   <= 16'sh0000;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      acc   <= next_acc;
      busy  <= next_busy;
    end
  end

  trig_fast_a: assert property (@(posedge clock) disable iff (rst)
    trig && cfg.en |=> busy && count == $past(cfg.settle))
    else $error("gain change did not start fast settling");
  servo_hold_a: assert property (@(posedge clock) disable iff (rst)
    state == DC_HOLD && !trig |=> $stable(acc))
    else $error("trim moved while loop idle");
  hpf_track_a: assert property (@(posedge clock) disable iff (rst)
    state == DC_FAST && count == 8'h00 && cfg.en && cfg.hpf && !trig
    |=> state == DC_TRACK)
    else $error("high-pass mode did not resume tracking");
  hpf_track_c: cover property (@(posedge clock) disable iff (rst)
    state == DC_FAST ##1 state == DC_TRACK);
endmodule
`default_nettype wire

/* File: verilog/rx_gain_decode_control.sv */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rx_gain_decode_control (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  input  wire logic signed [7:0] adc_i,
  input  wire logic signed [7:0] adc_q,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [2:0]             lna_en,
  output logic [2:0]             filter_mode,
  output logic                   swap_i,
  output logic                   swap_q,
  output logic                   vcm_sel,
  output rx_gain_pkg::gain_set_t gain,
  output logic signed [7:0]      trim_i,
  output logic signed [7:0]      trim_q
);
  logic                  req;
  logic                  in_map;
  logic                  wr_pend;
  logic                  next_wr_pend;
  logic [5:0]            wr_idx;
  logic [5:0]            next_wr_idx;
  logic [31:0]           next_hrdata;
  logic [1:0]            band;
  logic [1:0]            next_band;
  logic [6:0]            rx_gain;
  logic [6:0]            next_rx_gain;
  logic [4:0]            gaincal;
  logic [4:0]            next_gaincal;
  logic                  next_vcm_sel;
  logic [2:0]            next_filter_mode;
  logic                  next_swap_i;
  logic                  next_swap_q;
  logic [3:0]            mixstep;
  logic [3:0]            next_mixstep;
  logic [3:0]            lnastep;
  logic [3:0]            next_lnastep;
  rx_gain_pkg::dco_cfg_t dco;
  rx_gain_pkg::dco_cfg_t next_dco;
  logic [2:0]            next_lna_en;
  logic                  busy_i;
  logic                  busy_q;
  logic [6:0]            rel;

  // hsize is accepted as-is: only whole-word transfers are issued
  assign req    = hsel && hready && htrans[1];
  assign in_map = (haddr[31:8] == 24'h000000);

  always_comb begin
    next_wr_pend     = req && hwrite && in_map;
    next_wr_idx      = haddr[7:2];
    next_hrdata      = 32'h00000000;
    next_band        = band;
    next_rx_gain     = rx_gain;
    next_gaincal     = gaincal;
    next_vcm_sel     = vcm_sel;
    next_filter_mode = filter_mode;
    next_swap_i      = swap_i;
    next_swap_q      = swap_q;
    next_mixstep     = mixstep;
    next_lnastep     = lnastep;
    next_dco         = dco;
    if (req && !hwrite && in_map) begin
      case (haddr[7:2])
        rx_gain_pkg::IDX_BAND: next_hrdata[1:0] = band;
        rx_gain_pkg::IDX_GAIN: next_hrdata[6:0] = rx_gain;
        rx_gain_pkg::IDX_CAL: begin
          next_hrdata[4:0] = gaincal;
          next_hrdata[rx_gain_pkg::CAL_VCM_BIT] = vcm_sel;
        end
        rx_gain_pkg::IDX_CFG: begin
          next_hrdata[2:0] = filter_mode;
          next_hrdata[rx_gain_pkg::CFG_SWAPI] = swap_i;
          next_hrdata[rx_gain_pkg::CFG_SWAPQ] = swap_q;
          next_hrdata[rx_gain_pkg::CFG_DHPF]  = dco.hpf;
          next_hrdata[rx_gain_pkg::CFG_DEN]   = dco.en;
        end
        rx_gain_pkg::IDX_STEP: next_hrdata[7:0] = {lnastep, mixstep};
        rx_gain_pkg::IDX_DCO:
          next_hrdata[15:0] = {dco.settle, dco.slow_shift,
                               dco.fast_shift};
        rx_gain_pkg::IDX_STAT: begin
          next_hrdata[10:0] = gain;
          next_hrdata[rx_gain_pkg::STAT_REL_LSB +: 7] = rel;
          next_hrdata[rx_gain_pkg::STAT_BUSY] = busy_i | busy_q;
        end
        default: next_hrdata = 32'h00000000;
      endcase
    end
    // Write lands at the end of the data phase
    if (wr_pend) begin
      case (wr_idx)
        rx_gain_pkg::IDX_BAND: next_band = hwdata[1:0];
        rx_gain_pkg::IDX_GAIN: next_rx_gain = hwdata[6:0];
        rx_gain_pkg::IDX_CAL: begin
          next_gaincal = hwdata[4:0];
          next_vcm_sel = hwdata[rx_gain_pkg::CAL_VCM_BIT];
        end
        rx_gain_pkg::IDX_CFG: begin
          next_filter_mode = hwdata[2:0];
          next_swap_i = hwdata[rx_gain_pkg::CFG_SWAPI];
          next_swap_q = hwdata[rx_gain_pkg::CFG_SWAPQ];
          next_dco.hpf = hwdata[rx_gain_pkg::CFG_DHPF];
          next_dco.en  = hwdata[rx_gain_pkg::CFG_DEN];
        end
        rx_gain_pkg::IDX_STEP: begin
          next_mixstep = hwdata[3:0];
          next_lnastep = hwdata[rx_gain_pkg::STEP_LNA_LSB +: 4];
        end
        rx_gain_pkg::IDX_DCO: begin
          next_dco.fast_shift = hwdata[3:0];
          next_dco.slow_shift = hwdata[rx_gain_pkg::DCO_SLOW_LSB +: 4];
          next_dco.settle = hwdata[rx_gain_pkg::DCO_SET_LSB +: 8];
        end
        default: ;
      endcase
    end
    next_lna_en = 3'h0;
    if (next_band != 2'h0) begin
      next_lna_en[next_band - 2'h1] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend     <= 1'b0;
      wr_idx      <= 6'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      band        <= 2'h0;
      lna_en      <= 3'h0;
      rx_gain     <= rx_gain_pkg::RST_GAIN;
      gaincal     <= rx_gain_pkg::RST_CAL;
      vcm_sel     <= 1'b0;
      filter_mode <= rx_gain_pkg::FM_WCDMA7;
      swap_i      <= 1'b0;
      swap_q      <= 1'b0;
      mixstep     <= rx_gain_pkg::RST_MIXSTEP;
      lnastep     <= rx_gain_pkg::RST_LNASTEP;
      dco         <= '{fast_shift: rx_gain_pkg::RST_FAST,
                       slow_shift: rx_gain_pkg::RST_SLOW,
                       settle: rx_gain_pkg::RST_SETTLE,
                       hpf: 1'b0, en: 1'b0};
    end else begin
      wr_pend     <= next_wr_pend;
      wr_idx      <= next_wr_idx;
      hrdata      <= next_hrdata;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      band        <= next_band;
      lna_en      <= next_lna_en;
      rx_gain     <= next_rx_gain;
      gaincal     <= next_gaincal;
      vcm_sel     <= next_vcm_sel;
      filter_mode <= next_filter_mode;
      swap_i      <= next_swap_i;
      swap_q      <= next_swap_q;
      mixstep     <= next_mixstep;
      lnastep     <= next_lnastep;
      dco         <= next_dco;
    end
  end

  // Gain decode
  logic                  gsm;
  int                    rel_i;
  int                    bb;
  int                    n_lna;
  int                    n_mix;
  int                    n_filt;
  int                    n_vga;
  logic [6:0]            next_rel;
  rx_gain_pkg::gain_set_t next_gain;
  logic                  dco_trig;
  logic                  next_trig;

  assign gsm = (filter_mode == rx_gain_pkg::FM_GSM);

  always_comb begin
    // Gain above the fixed mixer and VGA bases
    rel_i = int'(rx_gain) - int'(gaincal)
          + (gsm ? rx_gain_pkg::X_GSM : rx_gain_pkg::X_WCDMA)
          - (gsm ? rx_gain_pkg::MIX_BASE_GSM
                 : rx_gain_pkg::MIX_BASE_WCDMA)
          - rx_gain_pkg::VGA_BASE;
    if (rel_i < 0) begin
      rel_i = 0;
    end else if (rel_i > rx_gain_pkg::REL_MAX) begin
      rel_i = rx_gain_pkg::REL_MAX;
    end
    next_rel = 7'(rel_i);
    n_lna = 0;
    n_mix = 0;
    for (int k = 0; k < rx_gain_pkg::MIX_MAX; k++) begin
      if (rel_i >= rx_gain_pkg::THR_UNIT * int'(mixstep)
                   + rx_gain_pkg::STEP_RF * k) begin
        n_mix = k + 1;
      end
    end
    for (int k = 0; k < rx_gain_pkg::LNA_MAX; k++) begin
      if (rel_i >= rx_gain_pkg::THR_UNIT * int'(lnastep)
                   + rx_gain_pkg::STEP_RF * k) begin
        n_lna = k + 1;
      end
    end
    // RF steps taken early may leave less than zero for baseband
    bb = rel_i - rx_gain_pkg::STEP_RF * (n_lna + n_mix);
    if (bb < 0) begin
      bb = 0;
    end
    n_filt = 0;
    for (int k = 1; k <= rx_gain_pkg::FILT_MAX; k++) begin
      if (bb >= rx_gain_pkg::STEP_FILT * k) begin
        n_filt = k;
      end
    end
    n_vga = bb - rx_gain_pkg::STEP_FILT * n_filt;
    if (n_vga > rx_gain_pkg::VGA_MAX) begin
      n_vga = rx_gain_pkg::VGA_MAX;
    end
    next_gain.lna  = 2'(n_lna);
    next_gain.mix  = 2'(n_mix);
    next_gain.filt = 2'(n_filt);
    next_gain.vga  = 5'(n_vga);
    next_trig = (next_gain != gain);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain     <= '0;
      rel      <= 7'h00;
      dco_trig <= 1'b0;
    end else begin
      gain     <= next_gain;
      rel      <= next_rel;
      dco_trig <= next_trig;
    end
  end

  dco_channel dco_ch_i (
    .clock (clock),
    .rst   (rst),
    .trig  (dco_trig),
    .cfg   (dco),
    .adc   (adc_i),
    .trim  (trim_i),
    .busy  (busy_i)
  );

  dco_channel dco_ch_q (
    .clock (clock),
    .rst   (rst),
    .trig  (dco_trig),
    .cfg   (dco),
    .adc   (adc_q),
    .trim  (trim_q),
    .busy  (busy_q)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  lna_select_a: assert property (
    ##1 lna_en == ((band == 2'h0) ? 3'h0 : 3'(3'h1 << (band - 2'h1))))
    else $error("LNA enable does not follow band field");
  filt_write_a: assert property (
    wr_pend && wr_idx == rx_gain_pkg::IDX_CFG
    |=> filter_mode == $past(hwdata[2:0]) && swap_q == $past(hwdata[5]))
    else $error("filter mode write lost");
  swap_write_a: assert property (
    wr_pend && wr_idx == rx_gain_pkg::IDX_CFG |=> swap_i == $past(hwdata[4]))
    else $error("swap bit write lost");
  vcm_write_a: assert property (
    wr_pend && wr_idx == rx_gain_pkg::IDX_CAL
    |=> vcm_sel == $past(hwdata[8]) && gaincal == $past(hwdata[4:0]))
    else $error("common-mode or calibration write lost");
  stage_range_a: assert property (
    gain.lna <= 2'h3 && gain.mix <= 2'h2 && gain.filt <= 2'h3)
    else $error("stage step out of range");
  vga_range_a: assert property (gain.vga <= 5'd24)
    else $error("VGA step out of range");
  eff_gain_a: assert property (
    rx_gain == 7'd80 && gaincal == 5'd6 && !gsm && $stable(rx_gain)
    && $stable(gaincal) && $stable(filter_mode) |=> rel == 7'd70)
    else $error("effective gain offset wrong");
  gain_write_a: assert property (
    wr_pend && wr_idx == rx_gain_pkg::IDX_GAIN
    |=> rx_gain == $past(hwdata[6:0]))
    else $error("gain write lost");
  mix_thresh_a: assert property (
    rel < 7'(4 * mixstep) && $stable(mixstep) |-> gain.mix == 2'h0)
    else $error("mixer stepped below its threshold");
  trig_change_a: assert property ($changed(gain) |-> dco_trig)
    else $error("gain change did not trigger offset loop");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");

  gsm_mode_c: cover property (gsm && gain.mix == 2'h2);
  full_gain_c: cover property (gain.vga == 5'd24 && gain.filt == 2'h3);
  lna_step_c: cover property ($changed(gain.lna) ##[1:4] busy_i);
endmodule
`default_nettype wire

/* File: bench/rx_gain_decode_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_gain_decode_control_test;
  logic                   clock;
  logic                   rst;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [31:0]            hwdata;
  logic signed [7:0]      adc_i;
  logic signed [7:0]      adc_q;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [2:0]             lna_en;
  logic [2:0]             filter_mode;
  logic                   swap_i;
  logic                   swap_q;
  logic                   vcm_sel;
  rx_gain_pkg::gain_set_t gain;
  logic signed [7:0]      trim_i;
  logic signed [7:0]      trim_q;
  int                     fail_count;
  int                     check_count;
  int                     cycles;

  rx_gain_decode_control DUT (
    .clock       (clock),
    .rst         (rst),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (3'h2),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .adc_i       (adc_i),
    .adc_q       (adc_q),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .lna_en      (lna_en),
    .filter_mode (filter_mode),
    .swap_i      (swap_i),
    .swap_q      (swap_q),
    .vcm_sel     (vcm_sel),
    .gain        (gain),
    .trim_i      (trim_i),
    .trim_q      (trim_q)
  );

  always #50 clock = ~clock;

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One idle cycle between transfers avoids the read-after-write hazard
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    check(r, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  function automatic logic [17:0] decode(input int rx, input int cal,
                                         input int ms, input int ls,
                                         input bit gsm);
    int rel;
    int m;
    int l;
    int bb;
    int f;
    int v;
    rel = gsm ? rx - cal + rx_gain_pkg::X_GSM - rx_gain_pkg::MIX_BASE_GSM
              : rx - cal + rx_gain_pkg::X_WCDMA - rx_gain_pkg::MIX_BASE_WCDMA;
    rel = rel - rx_gain_pkg::VGA_BASE;
    if (rel < 0) rel = 0;
    if (rel > rx_gain_pkg::REL_MAX) rel = rx_gain_pkg::REL_MAX;
    m = 0;
    l = 0;
    for (int k = 0; k < 2; k++) if (rel >= 4 * ms + 6 * k) m++;
    for (int k = 0; k < 3; k++) if (rel >= 4 * ls + 6 * k) l++;
    bb = rel - 6 * (l + m);
    if (bb < 0) bb = 0;
    f = bb / 12;
    if (f > 3) f = 3;
    v = bb - 12 * f;
    if (v > 24) v = 24;
    return {7'(rel), 2'(l), 2'(m), 2'(f), 5'(v)};
  endfunction

  task automatic gain_case(input int rx, input int cal, input int ms,
                           input int ls, input bit gsm);
    logic [17:0] e;
    logic [10:0] old;
    wait_cyc(3);
    old = gain;
    e = decode(rx, cal, ms, ls, gsm);
    wr_reg(rx_gain_pkg::IDX_GAIN, 32'(rx));
    repeat (4) begin
      @(negedge clock);
      check(32'(gain === old || gain === e[10:0]), 32'h1);
    end
    check(32'(gain), 32'(e[10:0]));
    rd_chk(rx_gain_pkg::IDX_STAT, {9'h0, e[17:11], 5'h0, e[10:0]});
  endtask

  task automatic test_reset;
    check({12'h0, lna_en, filter_mode, swap_i, swap_q, vcm_sel, gain}, 0);
    check({15'h0, hresp, trim_i, trim_q}, 32'h0);
    rd_chk(rx_gain_pkg::IDX_CAL, 32'h8);
    rd_chk(rx_gain_pkg::IDX_STEP, 32'h84);
    rd_chk(rx_gain_pkg::IDX_DCO, 32'h4062);
    rd_chk(rx_gain_pkg::IDX_STAT, 32'h0);
    wr_reg(6'h05, 32'hffff_ffff);
    rd_chk(6'h05, 32'h0);
    wr_reg(rx_gain_pkg::IDX_STAT, 32'hffff_ffff);
    rd_chk(rx_gain_pkg::IDX_STAT, 32'h0);
  endtask

  task automatic test_band;
    for (int b = 0; b < 4; b++) begin
      wr_reg(rx_gain_pkg::IDX_BAND, 32'(b));
      wait_cyc(2);
      check(32'(lna_en), b == 0 ? 32'h0 : 32'h1 << (b - 1));
      rd_chk(rx_gain_pkg::IDX_BAND, 32'(b));
    end
  endtask

  task automatic test_cfg;
    logic [31:0] w[4] = '{32'h10, 32'h21, 32'h32, 32'h00};
    foreach (w[i]) begin
      wr_reg(rx_gain_pkg::IDX_CFG, w[i]);
      wait_cyc(2);
      check({27'h0, filter_mode, swap_i, swap_q},
            {27'h0, w[i][2:0], w[i][4], w[i][5]});
    end
    wr_reg(rx_gain_pkg::IDX_CAL, 32'h108);
    wait_cyc(2);
    check(32'(vcm_sel), 32'h1);
    rd_chk(rx_gain_pkg::IDX_CAL, 32'h108);
    wr_reg(rx_gain_pkg::IDX_CAL, 32'h8);
    wait_cyc(2);
    check(32'(vcm_sel), 32'h0);
  endtask

  task automatic test_gain;
    int rxs[8] = '{4, 20, 26, 40, 52, 70, 94, 127};
    foreach (rxs[i]) gain_case(rxs[i], 8, 4, 8, 1'b0);
    // Six dB of calibration offset: 80 dB asked, 74 dB used inside
    wr_reg(rx_gain_pkg::IDX_CAL, 32'h6);
    gain_case(80, 6, 4, 8, 1'b0);
    wr_reg(rx_gain_pkg::IDX_CAL, 32'h3);
    gain_case(60, 3, 4, 8, 1'b0);
    gain_case(127, 3, 4, 8, 1'b0);
    wr_reg(rx_gain_pkg::IDX_STEP, 32'h32);
    wr_reg(rx_gain_pkg::IDX_CFG, 32'(rx_gain_pkg::FM_GSM));
    gain_case(30, 3, 2, 3, 1'b1);
    gain_case(85, 3, 2, 3, 1'b1);
    wr_reg(rx_gain_pkg::IDX_CFG, 32'(rx_gain_pkg::FM_WCDMA5));
    gain_case(44, 3, 2, 3, 1'b0);
  endtask

  task automatic test_dco;
    logic [31:0] r;
    logic [15:0] t;
    wr_reg(rx_gain_pkg::IDX_DCO, 32'h0862);
    adc_i <= 8'sh20;
    adc_q <= -8'sh20;
    // Disabled loop drops the trigger and holds the trims
    gain_case(50, 3, 2, 3, 1'b0);
    check(32'({trim_i, trim_q}), 32'h0);
    wr_reg(rx_gain_pkg::IDX_CFG, 32'h200);
    wr_reg(rx_gain_pkg::IDX_GAIN, 32'd64);
    wait_cyc(2);
    bus(1'b0, rx_gain_pkg::IDX_STAT, 32'h0, r);
    check(32'(r[24]), 32'h1);
    wait_cyc(20);
    bus(1'b0, rx_gain_pkg::IDX_STAT, 32'h0, r);
    check(32'(r[24]), 32'h0);
    check(32'({trim_i[7], trim_q[7], trim_i != 0}), 32'h5);
    t = {trim_i, trim_q};
    adc_i <= -8'sh20;
    adc_q <= 8'sh20;
    wait_cyc(10);
    check(32'({trim_i, trim_q}), 32'(t));
    wr_reg(rx_gain_pkg::IDX_CFG, 32'h300);
    wr_reg(rx_gain_pkg::IDX_GAIN, 32'd70);
    wait_cyc(25);
    t = {trim_i, trim_q};
    wait_cyc(10);
    check(32'($signed(trim_i) > $signed(t[15:8])), 32'h1);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    adc_i = 8'sh00;
    adc_q = 8'sh00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wait_cyc(1);
    test_reset();
    test_band();
    test_cfg();
    test_gain();
    test_dco();
    give_verdict;
  end
endmodule
`default_nettype wire
